/* File: trig_regs.vh */
// Purpose: register offsets, field positions, reset values and timing for the trigger handshake
// Assumes: 32-bit AHB-Lite register bus, 10 MHz hclk
// Notes: header of definitions only
`ifndef TRIG_REGS_VH
`define TRIG_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_LINES 8'h04
`define OFF_MCOUNT 8'h08
`define OFF_LCOUNT 8'h0C
`define OFF_PULSE 8'h10
`define OFF_STATUS 8'h14

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define B_SEMI 0
`define B_CONT 1
`define B_INIT 2
`define B_ABORT 3
`define B_ARM_BUS 4
`define B_SCAN_BUS 5
`define B_MEAS_BUS 6
`define B_ARM_SRC 7
`define B_SCAN_SRC 8
`define B_MEAS_SRC 9
`define B_DEFAULTS 10
`define CTRL_RST 10'h042 // continuous initiation, measure layer waits on the bus

// ----------------------------------------------------------------
// line selection and count reset values
// ----------------------------------------------------------------
`define IN_LINE_RST 3'h1
`define OUT_LINE_RST 3'h2
`define SEMI_LINE_RST 3'h1
`define MCOUNT_RST 16'h000A
`define ARM_CNT_RST 8'h01
`define SCAN_CNT_RST 8'h00

// ----------------------------------------------------------------
// timing: output pulse width
// ----------------------------------------------------------------
`define CLK_MHZ 10
`define PULSE_NS 10000
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`define GUARD_CYC 3'h4

`endif

/* File: line_sync.v */
// Purpose: synchronise the trigger bus lines and report their edges
// Assumes: lines are asynchronous to hclk
// Notes: a level counts once the second and third stages agree
`timescale 1ns/1ns
module line_sync #(
   parameter W = 6
) (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // raw lines and filtered results
   input wire [W-1:0] line_in,
   output wire [W-1:0] level,
   output wire [W-1:0] fall,
   output wire [W-1:0] rise
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_line
         reg s1_q, s2_q, s3_q, lvl_q, lvl_d1_q;
         // three stages; the stable level only moves when stages two and three agree
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1_q <= 1'b1;
               s2_q <= 1'b1;
               s3_q <= 1'b1;
               lvl_q <= 1'b1;
               lvl_d1_q <= 1'b1;
            end else begin
               s1_q <= line_in[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  lvl_q <= s3_q;
               end
               lvl_d1_q <= lvl_q;
            end
         end
         assign level[i] = lvl_q;
         assign fall[i] = lvl_d1_q & ~lvl_q;
         assign rise[i] = ~lvl_d1_q & lvl_q;
      end
   endgenerate

endmodule

/* File: trig_handshake.v */
// Purpose: layered trigger model exchanging triggers over a multi_line_trigger_bus
// Assumes: measurement engine on hclk answers meas_start with a meas_done pulse
// Notes: open-drain lines, pulled low when trig_oe is high
// Functional notes
// - semi-sync uses one shared line both ways
// - line idles high; falling edge is a trigger
// - release rising edge triggers the waiting source
// - only pull low or release, never drive high
// - source pulls line low after measurement
// - acceptor holds line low while measuring
// - release line on completion, then wait again
// - async layer uses separate input and output lines
// - source control skips first wait only
// - first-pass skip rearmed each outer pass
// - async input pulse starts one measurement, then pulse
// - after outer passes used up, return idle
// - immediate arm and scan go to measure
// - defaults select continuous initiation
// - one source, all others acceptors
`timescale 1ns/1ns
`include "trig_regs.vh"
module trig_handshake (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // trigger bus, open drain
   input wire [5:0] trig_in,
   output wire [5:0] trig_out,
   output wire [5:0] trig_oe,
   // measurement engine
   output reg meas_start,
   input wire meas_done,
   // state
   output wire armed,
   output wire waiting
);

   // ----------------------------------------------------------------
   // states and decode helpers
   // ----------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ARM = 3'h1;
   localparam [2:0] S_SCAN = 3'h2;
   localparam [2:0] S_MEAS = 3'h3;
   localparam [2:0] S_RUN = 3'h4;
   localparam [2:0] S_OUT = 3'h5;
   localparam integer PW_I = `PULSE_CYC;
   localparam [7:0] PW_RST = PW_I[7:0];

   // line number 1..6 to bus index, out-of-range numbers clamp
   function [2:0] lidx;
      input [2:0] n;
      begin
         if (n == 3'h0) begin
            lidx = 3'h0;
         end else if (n > 3'h6) begin
            lidx = 3'h5;
         end else begin
            lidx = n - 3'h1;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // configuration and state registers
   // ----------------------------------------------------------------
   reg [9:0] ctrl_q;
   reg [2:0] in_line_q, out_line_q, semi_line_q;
   reg [15:0] mcount_q;
   reg [7:0] arm_cnt_q, scan_cnt_q, pw_q;
   reg [2:0] state_q;
   reg [15:0] meas_n_q;
   reg [7:0] scan_n_q, arm_n_q, pw_n_q;
   reg arm_first_q, scan_first_q, meas_first_q;
   reg drv_q;
   reg [2:0] drv_idx_q, guard_q;
   reg init_q, abort_q;
   reg ph_wr_q;
   reg [7:0] ph_addr_q;

   wire semi = ctrl_q[`B_SEMI];
   wire meas_src = ctrl_q[`B_MEAS_SRC];
   wire [5:0] lvl, fall, rise;

   // ----------------------------------------------------------------
   // line synchroniser
   // ----------------------------------------------------------------
   line_sync #(.W(6)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .line_in(trig_in),
      .level(lvl),
      .fall(fall),
      .rise(rise)
   );

   // edges seen while we drive, or shortly after, are our own
   wire quiet = ~drv_q & (guard_q == 3'h0);
   wire in_fall = fall[lidx(in_line_q)] & quiet;
   wire semi_fall = fall[lidx(semi_line_q)] & quiet;
   wire semi_rise = rise[lidx(semi_line_q)] & quiet;

   // ----------------------------------------------------------------
   // layer events
   // ----------------------------------------------------------------
   wire arm_ev = (arm_first_q & ctrl_q[`B_ARM_SRC]) | ~ctrl_q[`B_ARM_BUS] | in_fall;
   wire scan_ev = (scan_first_q & ctrl_q[`B_SCAN_SRC]) | ~ctrl_q[`B_SCAN_BUS] | in_fall;
   reg meas_ev;
   // measure layer: source of trigger depends on mode and control
   always @* begin
      if (meas_first_q && meas_src) begin
         meas_ev = 1'b1;
      end else if (!ctrl_q[`B_MEAS_BUS]) begin
         meas_ev = 1'b1;
      end else if (!semi) begin
         meas_ev = in_fall;
      end else if (meas_src) begin
         meas_ev = semi_rise;
      end else begin
         meas_ev = semi_fall;
      end
   end

   // layer completion; a count of zero means infinite
   wire meas_last = (mcount_q != 16'h0000) && (meas_n_q + 16'h0001 == mcount_q);
   wire scan_last = (scan_cnt_q != 8'h00) && (scan_n_q + 8'h01 == scan_cnt_q);
   wire arm_last = (arm_cnt_q != 8'h00) && (arm_n_q + 8'h01 == arm_cnt_q);

   // ----------------------------------------------------------------
   // trigger model sequencer
   // ----------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= S_IDLE;
         meas_n_q <= 16'h0000;
         scan_n_q <= 8'h00;
         arm_n_q <= 8'h00;
         pw_n_q <= 8'h00;
         arm_first_q <= 1'b1;
         scan_first_q <= 1'b1;
         meas_first_q <= 1'b1;
         drv_q <= 1'b0;
         drv_idx_q <= 3'h0;
         guard_q <= 3'h0;
         meas_start <= 1'b0;
      end else begin
         meas_start <= 1'b0;
         if (drv_q) begin
            guard_q <= `GUARD_CYC;
         end else if (guard_q != 3'h0) begin
            guard_q <= guard_q - 3'h1;
         end
         if (abort_q) begin
            state_q <= S_IDLE;
            drv_q <= 1'b0;
         end else begin
            case (state_q)
               S_IDLE: begin
                  if (ctrl_q[`B_CONT] || init_q) begin
                     arm_first_q <= 1'b1;
                     meas_n_q <= 16'h0000;
                     scan_n_q <= 8'h00;
                     arm_n_q <= 8'h00;
                     state_q <= S_ARM;
                  end
               end
               S_ARM: begin
                  if (arm_ev) begin
                     arm_first_q <= 1'b0;
                     scan_first_q <= 1'b1;
                     state_q <= S_SCAN;
                  end
               end
               S_SCAN: begin
                  if (scan_ev) begin
                     scan_first_q <= 1'b0;
                     meas_first_q <= 1'b1;
                     state_q <= S_MEAS;
                  end
               end
               S_MEAS: begin
                  if (meas_ev) begin
                     meas_first_q <= 1'b0;
                     meas_start <= 1'b1;
                     // acceptor holds the shared line for the whole action
                     if (semi && !meas_src) begin
                        drv_q <= 1'b1;
                        drv_idx_q <= lidx(semi_line_q);
                     end
                     state_q <= S_RUN;
                  end
               end
               S_RUN: begin
                  if (meas_done) begin
                     if (semi && !meas_src) begin
                        drv_q <= 1'b0;
                        pw_n_q <= 8'h00;
                     end else begin
                        // async pulse or source pull-down, both of fixed width
                        drv_q <= 1'b1;
                        drv_idx_q <= semi ? lidx(semi_line_q) : lidx(out_line_q);
                        pw_n_q <= pw_q;
                     end
                     state_q <= S_OUT;
                  end
               end
               S_OUT: begin
                  if (pw_n_q > 8'h01) begin
                     pw_n_q <= pw_n_q - 8'h01;
                  end else begin
                     drv_q <= 1'b0;
                     if (!meas_last) begin
                        meas_n_q <= meas_n_q + 16'h0001;
                        state_q <= S_MEAS;
                     end else if (!scan_last) begin
                        meas_n_q <= 16'h0000;
                        scan_n_q <= scan_n_q + 8'h01;
                        state_q <= S_SCAN;
                     end else if (!arm_last) begin
                        meas_n_q <= 16'h0000;
                        scan_n_q <= 8'h00;
                        arm_n_q <= arm_n_q + 8'h01;
                        state_q <= S_ARM;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // open-drain drive: data always low, only the enable moves
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_drv
         assign trig_oe[g] = drv_q && (drv_idx_q == g);
      end
   endgenerate
   assign trig_out = 6'h00;
   assign armed = (state_q != S_IDLE);
   assign waiting = (state_q == S_MEAS);

   // ----------------------------------------------------------------
   // ahb-lite slave: zero wait states, always okay
   // ----------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   wire take = hsel & htrans[1] & hready;

   reg [31:0] rd_d;
   // read mux sampled in the address phase so hrdata comes from a flop
   always @* begin
      case (haddr[7:0])
         `OFF_CTRL: rd_d = {22'h0, ctrl_q[9:4], 2'b00, ctrl_q[1:0]};
         `OFF_LINES: rd_d = {21'h0, semi_line_q, 1'b0, out_line_q, 1'b0, in_line_q};
         `OFF_MCOUNT: rd_d = {16'h0000, mcount_q};
         `OFF_LCOUNT: rd_d = {16'h0000, scan_cnt_q, arm_cnt_q};
         `OFF_PULSE: rd_d = {24'h000000, pw_q};
         `OFF_STATUS: rd_d = {meas_n_q, 2'b00, lvl, 5'h00, state_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   // address phase capture and register writes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_q <= 1'b0;
         ph_addr_q <= 8'h00;
         hrdata <= 32'h00000000;
         ctrl_q <= `CTRL_RST;
         in_line_q <= `IN_LINE_RST;
         out_line_q <= `OUT_LINE_RST;
         semi_line_q <= `SEMI_LINE_RST;
         mcount_q <= `MCOUNT_RST;
         arm_cnt_q <= `ARM_CNT_RST;
         scan_cnt_q <= `SCAN_CNT_RST;
         pw_q <= PW_RST;
         init_q <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         init_q <= 1'b0;
         abort_q <= 1'b0;
         if (hready) begin
            ph_wr_q <= take & hwrite;
            ph_addr_q <= haddr[7:0];
         end
         if (take && !hwrite) begin
            hrdata <= rd_d;
         end
         if (ph_wr_q) begin
            case (ph_addr_q)
               `OFF_CTRL: begin
                  if (hwdata[`B_DEFAULTS]) begin
                     // bench defaults: continuous initiation, input and shared line one, output line two
                     ctrl_q <= `CTRL_RST;
                     in_line_q <= `IN_LINE_RST;
                     out_line_q <= `OUT_LINE_RST;
                     semi_line_q <= `SEMI_LINE_RST;
                     mcount_q <= `MCOUNT_RST;
                     arm_cnt_q <= `ARM_CNT_RST;
                     scan_cnt_q <= `SCAN_CNT_RST;
                     pw_q <= PW_RST;
                  end else begin
                     // command bits are pulses and are not stored
                     ctrl_q <= {hwdata[9:4], 2'b00, hwdata[1:0]};
                     init_q <= hwdata[`B_INIT];
                     abort_q <= hwdata[`B_ABORT];
                  end
               end
               `OFF_LINES: begin
                  in_line_q <= hwdata[2:0];
                  out_line_q <= hwdata[6:4];
                  semi_line_q <= hwdata[10:8];
               end
               `OFF_MCOUNT: mcount_q <= hwdata[15:0];
               `OFF_LCOUNT: begin
                  arm_cnt_q <= hwdata[7:0];
                  scan_cnt_q <= hwdata[15:8];
               end
               `OFF_PULSE: pw_q <= hwdata[7:0];
               default: begin
                  pw_q <= pw_q;
               end
            endcase
         end
      end
   end

endmodule

/* File: trig_handshake_assertions.sv */
// Purpose: port checks for trig_handshake
// Assumes: each meas_start is answered by one meas_done
// Notes: bound from the bench top file
`timescale 1ns/1ns
module trig_handshake_assertions (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   // trigger bus
   input wire [5:0] trig_in,
   input wire [5:0] trig_out,
   input wire [5:0] trig_oe,
   // engine and state
   input wire meas_start,
   input wire meas_done,
   input wire armed,
   input wire waiting
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // -----------------------------------------
   // helper and assertions
   // -----------------------------------------
   reg busy_q;
   // a measurement is outstanding until its done pulse
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         busy_q <= 1'b0;
      else if (meas_start)
         busy_q <= 1'b1;
      else if (meas_done)
         busy_q <= 1'b0;
   end
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   a_never_high: assert property (trig_out == 6'h00)
      else $error("trigger line driven high");
   a_start_pulse: assert property (meas_start |=> !meas_start)
      else $error("start pulse too long");
   a_one_meas: assert property (meas_start |-> !busy_q)
      else $error("start while measuring");
   a_start_armed: assert property (meas_start |-> armed)
      else $error("start while idle");
   a_wait_armed: assert property (waiting |-> armed)
      else $error("waiting while idle");
   a_idle_free: assert property (!armed |-> trig_oe == 6'h00)
      else $error("line held while idle");
   a_pull_cause: assert property ($rose(|trig_oe) |-> meas_start || $past(meas_done))
      else $error("line pulled without cause");
   a_rdata_hold: assert property (!$stable(hrdata) |-> $past(hsel && htrans[1] && !hwrite))
      else $error("read data moved without read");
endmodule

/* File: trig_peer.sv */
// Purpose: peer instrument on the trigger bus
// Assumes: bus is the wired-AND level with a pull-up
// Notes: ignores edges while and just after it drives
`timescale 1ns/1ns
module trig_peer (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // setup
   input wire semi,
   input wire src,
   input wire go,
   input wire [2:0] in_no,
   input wire [2:0] out_no,
   input wire [7:0] hold,
   // trigger bus
   input wire [5:0] bus,
   output wire [5:0] oe
);
   reg prev_q;
   reg own_q;
   integer dly_q;
   integer pw_q;
   wire seen;
   wire ev;
   assign seen = bus[in_no - 3'h1];
   // semi source steps on a rise, all others act on a fall
   assign ev = go || (!own_q && pw_q == 0 &&
      ((semi && src) ? (!prev_q && seen) : (prev_q && !seen)));
   // only pulls low or releases
   assign oe = (pw_q != 0) ? (6'h01 << (out_no - 3'h1)) : 6'h00;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= 1'b1;
         own_q <= 1'b0;
         dly_q <= 0;
         pw_q <= 0;
      end else begin
         prev_q <= seen;
         own_q <= (pw_q != 0); // masks the rise of its own release
         // an acceptor holds at once; a source settles first, so its next pull is a clear fall
         if (ev && semi && !src)
            pw_q <= hold;
         else if (ev)
            dly_q <= hold;
         else if (dly_q == 1) begin
            dly_q <= 0;
            pw_q <= 6;
         end else if (dly_q > 1)
            dly_q <= dly_q - 1;
         else if (pw_q > 0)
            pw_q <= pw_q - 1;
      end
   end
endmodule

/* File: trigger_handshake_controller_bench.sv */
// Purpose: self-checking bench for trig_handshake
// Assumes: zero-wait slave, engine answers every start
// Notes: peer model plays the far instrument
`timescale 1ns/1ns
`include "trig_regs.vh"
`define CHK(n, e, g) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
   fails = fails + 1; $display("Error %s expected %0h seen %0h", n, e, g); end end
module trigger_handshake_controller_bench;
   reg hclk, hresetn, hsel, hwrite, meas_done, semi, src, go, done_q;
   reg [31:0] haddr, hwdata, rd;
   reg [1:0] htrans;
   reg [2:0] in_no, out_no, dev_in, dev_out;
   reg [7:0] hold;
   reg [5:0] oe_seen;
   wire hreadyout, hresp, meas_start, armed, waiting;
   wire [31:0] hrdata;
   wire [5:0] trig_out, trig_oe, peer_oe, bus;
   integer fails, total_checks, seed, eng, n_meas, n_out, run, cyc;
   assign bus = ~(trig_oe | peer_oe); // pulled up, any party pulls low
   trig_handshake DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig_in(bus),
      .trig_out(trig_out), .trig_oe(trig_oe), .meas_start(meas_start),
      .meas_done(meas_done), .armed(armed), .waiting(waiting));
   trig_peer peer (.hclk(hclk), .hresetn(hresetn), .semi(semi), .src(src), .go(go),
      .in_no(in_no), .out_no(out_no), .hold(hold), .bus(bus), .oe(peer_oe));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   task wrap_up(input integer late);
      begin
         if (late != 0)
            fails = fails + 1;
         $display("checks %0d fails %0d", total_checks, fails);
         if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   // -----------------------------------------
   // bus tasks, engine model and monitors
   // -----------------------------------------
   task ahb(input w, input [7:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         haddr <= {24'h0, a};
         hwrite <= w;
         htrans <= 2'h2;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         htrans <= 2'h0;
         hsel <= 1'b0;
         hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         rd = hrdata;
      end
   endtask
   // engine answers after a random time; pulses and holds are watched
   always @(posedge hclk) begin
      meas_done <= 1'b0;
      done_q <= meas_done;
      cyc = cyc + 1;
      oe_seen = oe_seen | trig_oe;
      if (meas_start === 1'b1)
         n_meas = n_meas + 1;
      if (eng > 1)
         eng <= eng - 1;
      else if (eng == 1) begin
         eng <= 0;
         meas_done <= 1'b1;
      end else if (meas_start === 1'b1)
         eng <= 3 + {$random(seed)} % 16;
      if (!semi && trig_oe[dev_out - 3'h1] === 1'b1)
         run = run + 1;
      else if (run > 0) begin
         `CHK("pulse width", 5, run)
         n_out = n_out + 1;
         run = 0;
      end
      if (semi && src && meas_done === 1'b1) `CHK("held low", 1'b1, trig_oe[0])
      if (semi && src && done_q === 1'b1) `CHK("released", 1'b0, trig_oe[0])
      if (semi && !src && meas_start === 1'b1 && n_meas == 2) `CHK("rise", 1'b1, bus[0])
      if (cyc > 40000)
         wrap_up(1);
   end
   task start(input [31:0] ctrl);
      begin
         n_meas = 0;
         oe_seen = 6'h00;
         ahb(1, `OFF_CTRL, ctrl);
         repeat (10) @(posedge hclk);
         go <= 1'b1;
         @(posedge hclk);
         go <= 1'b0;
         while (armed !== 1'b0) @(posedge hclk);
         repeat (80) @(posedge hclk);
      end
   endtask
   initial begin
      seed = 32'h24A0;
      {fails, total_checks, eng, n_meas, n_out, run, cyc} = 0;
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, meas_done, done_q} = 0;
      {semi, src, go, oe_seen} = 0;
      {in_no, out_no, dev_out, hold} = {3'h1, 3'h1, 3'h1, 8'h04};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      ahb(0, `OFF_CTRL, 0);
      `CHK("ctrl", 32'h42, rd)
      ahb(0, `OFF_LINES, 0);
      `CHK("lines", 32'h121, rd)
      ahb(0, `OFF_MCOUNT, 0);
      `CHK("mcount", 32'hA, rd)
      ahb(0, `OFF_LCOUNT, 0);
      `CHK("lcount", 32'h1, rd)
      ahb(0, `OFF_PULSE, 0);
      `CHK("pulse", 32'h64, rd)
      ahb(0, 8'h18, 0);
      `CHK("unmapped", 32'h0, rd)
      ahb(0, `OFF_STATUS, 0);
      `CHK("state", 3'h3, rd[2:0])
      `CHK("waiting", 1'b1, waiting)
      ahb(1, `OFF_CTRL, 0);
      ahb(1, `OFF_CTRL, 32'h400);
      ahb(0, `OFF_CTRL, 0);
      `CHK("defaults", 32'h42, rd)
      ahb(1, `OFF_CTRL, 32'h8);
      repeat (3) @(posedge hclk);
      `CHK("abort", 1'b0, armed)
      $display("test registers done");
      dev_in = 3'h1 + {$random(seed)} % 6;
      dev_out = dev_in % 6 + 3'h1;
      ahb(1, `OFF_LINES, {21'h0, 3'h1, 1'b0, dev_out, 1'b0, dev_in});
      ahb(1, `OFF_PULSE, 5);
      ahb(1, `OFF_MCOUNT, 3);
      ahb(1, `OFF_LCOUNT, 32'h0101);
      {in_no, out_no} = {dev_out, dev_in};
      start(32'h44);
      `CHK("async meas", 3, n_meas)
      `CHK("async pulses", 3, n_out)
      `CHK("out line", 6'h01 << (dev_out - 3'h1), oe_seen)
      $display("test async done");
      {semi, src, in_no, out_no, hold} = {2'b11, 3'h1, 3'h1, 8'h06};
      start(32'h45);
      `CHK("semi meas", 3, n_meas)
      $display("test semi acceptor done");
      ahb(1, `OFF_MCOUNT, 2);
      {src, hold} = {1'b0, 8'h14};
      start(32'h245);
      `CHK("source meas", 2, n_meas)
      `CHK("source pull", 1'b1, oe_seen[0])
      $display("test semi source done");
      wrap_up(0);
   end
endmodule
bind trig_handshake trig_handshake_assertions chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe),
   .meas_start(meas_start), .meas_done(meas_done), .armed(armed), .waiting(waiting));
